// ==== supervisor_smbus_consts.vh ====
// constants for the supervisor serial slave port and its control registers
`ifndef SUPERVISOR_SMBUS_CONSTS_VH
`define SUPERVISOR_SMBUS_CONSTS_VH

// register byte addresses inside the register sector
`define WRITE_LATCH_CONTROL_ADDR    8'h00
`define EEPROM_PROTECT_CONTROL_ADDR 8'h01
`define RESET_DELAY_CONTROL_ADDR    8'h02
`define OUTPUT_DELAY_CONTROL_ADDR   8'h03
`define FAULT_FLAGS_ADDR            8'hff

// field positions
`define WRITE_ENABLE_LATCH_BIT      7
`define HW_PROTECT_ENABLE_BIT       7
`define BLOCK_PROTECT_HI_BIT        4
`define BLOCK_PROTECT_LO_BIT        3
`define RESET_DELAY_SEL_HI_BIT      3
`define RESET_DELAY_SEL_LO_BIT      2
`define FAULT_FLAG_HI_BIT           3

// reset values
`define WRITE_ENABLE_LATCH_RESET    1'h0
`define HW_PROTECT_ENABLE_RESET     1'h0
`define BLOCK_PROTECT_RESET         2'h0
`define RESET_DELAY_SEL_RESET       2'h0
`define OUTPUT_DELAY_SEL_RESET      8'h00
`define FAULT_FLAGS_RESET           4'h0

// slave address layout and array constants
`define DEVICE_TYPE_PATTERN         4'ha
`define SECTOR_REGISTERS            1'h1
`define ARRAY_UPPER_QUARTER_BASE    8'hc0
`define ARRAY_READ_FILL             8'hff

// block-protect codes
`define PROTECT_NONE                2'h0
`define PROTECT_QUARTER             2'h1
`define PROTECT_HALF                2'h2
`define PROTECT_ALL                 2'h3

// nonvolatile write cycle: 5 ms of 100 MHz core clocks, sized to the cycle timer
`define NV_WRITE_CYCLES             20'h7a120

`endif

// ==== supervisor_smbus_slave_regs.v ====
// serial slave port and control/status registers of the supply supervisor
`include "supervisor_smbus_consts.vh"
`default_nettype none

// three-stage input synchroniser; output follows once stages two and three agree
module input_sync3 #(
    parameter WIDTH = 1
) (
    input  wire             i_clk,
    input  wire             i_rst,
    input  wire [WIDTH-1:0] i_async,
    output reg  [WIDTH-1:0] o_level
);
    reg [WIDTH-1:0] stage1;   // metastability catcher, read only by stage2
    reg [WIDTH-1:0] stage2;   // second stage
    reg [WIDTH-1:0] stage3;   // third stage, compared with stage2
    integer k;

    // shift chain plus agreement filter per bit
    always @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            stage1  <= {WIDTH{1'b1}};
            stage2  <= {WIDTH{1'b1}};
            stage3  <= {WIDTH{1'b1}};
            o_level <= {WIDTH{1'b1}};
        end else begin
            stage1 <= i_async;
            stage2 <= stage1;
            stage3 <= stage2;
            for (k = 0; k < WIDTH; k = k + 1) begin
                if (stage2[k] == stage3[k]) begin
                    o_level[k] <= stage3[k];
                end
            end
        end
    end
endmodule

module supervisor_smbus_slave_regs #(
    parameter [19:0] NV_WRITE_CYCLES = `NV_WRITE_CYCLES  // nonvolatile cycle length
) (
    input  wire       I_CORE_CLK,
    input  wire       I_RST,
    input  wire       I_SCL,
    input  wire       I_SDA,
    output reg        O_SDA_OUT,
    output reg        O_SDA_OE,
    input  wire       I_A1,
    input  wire       I_A0,
    input  wire       I_WRITE_PROTECT,
    input  wire       I_PROGRAM_VOLTAGE_OK,
    input  wire [3:0] I_SUPPLY_GOOD,
    output reg        O_WRITE_ENABLE,
    output reg        O_HW_PROTECT_ENABLE,
    output reg  [1:0] O_BLOCK_PROTECT,
    output reg  [1:0] O_RESET_DELAY_SEL,
    output reg  [7:0] O_OUTPUT_DELAY_SEL,
    output reg  [3:0] O_FAULT_FLAGS,
    output reg        O_NV_BUSY,
    output reg        O_STANDBY
);
    // transfer states
    localparam [2:0] ST_IDLE = 3'h0;  // waiting for a start
    localparam [2:0] ST_ADDR = 3'h1;  // slave address byte
    localparam [2:0] ST_WORD = 3'h2;  // word address byte
    localparam [2:0] ST_DATA = 3'h3;  // write data bytes
    localparam [2:0] ST_READ = 3'h4;  // transmitting to master

    wire [9:0] synced;          // filtered pin levels
    wire       scl_new;         // filtered clock
    wire       sda_new;         // filtered data
    reg        scl_q;           // previous clock level
    reg        sda_q;           // previous data level
    reg  [2:0] state;           // transfer state
    reg  [3:0] bitcnt;          // 0..7 data bits, 8 ack drive, 9 ack clock
    reg  [7:0] shreg;           // receive shifter
    reg  [7:0] txbyte;          // byte being sent
    reg  [7:0] word_addr;       // register / array address pointer
    reg  [7:0] pend_data;       // first data byte of a write
    reg        have_data;       // full data byte received, ack being driven
    reg        sector_regs;     // 1 = register sector, 0 = array
    reg        read_op;         // read bit of the address byte
    reg        pgm_fault;       // programming voltage dropped in a cycle
    reg [19:0] nv_cnt;          // nonvolatile cycle timer
    reg  [7:0] read_data;       // register read mux
    reg        array_locked;    // array address under block protection
    reg        hw_locked;       // hardware protection active

    // pins enter the core clock domain through the synchroniser
    input_sync3 #(.WIDTH(10)) u_sync (
        .i_clk   (I_CORE_CLK),
        .i_rst   (I_RST),
        .i_async ({I_SCL, I_SDA, I_A1, I_A0, I_WRITE_PROTECT,
                   I_PROGRAM_VOLTAGE_OK, I_SUPPLY_GOOD}),
        .o_level (synced)
    );
    assign scl_new = synced[9];
    assign sda_new = synced[8];

    // edge and condition detection on the filtered lines
    wire scl_rise = !scl_q && scl_new;
    wire scl_fall = scl_q && !scl_new;
    wire start_seen = scl_q && scl_new && sda_q && !sda_new;
    wire stop_seen  = scl_q && scl_new && !sda_q && sda_new;
    wire wp_pin = synced[5];
    wire pgm_ok = synced[4];
    wire [3:0] good = synced[3:0];
    wire addr_match = (shreg[7:4] == `DEVICE_TYPE_PATTERN)
                   && (shreg[3:2] == {synced[7], synced[6]});

    // register read mux and protection decode
    always @* begin
        read_data = `ARRAY_READ_FILL;  // array lives outside this block
        if (sector_regs) begin
            case (word_addr)
                `WRITE_LATCH_CONTROL_ADDR:
                    read_data = {O_WRITE_ENABLE, 7'h00};
                `EEPROM_PROTECT_CONTROL_ADDR:
                    read_data = {O_HW_PROTECT_ENABLE, 2'h0, O_BLOCK_PROTECT, 3'h0};
                `RESET_DELAY_CONTROL_ADDR:
                    read_data = {4'h0, O_RESET_DELAY_SEL, 2'h0};
                `OUTPUT_DELAY_CONTROL_ADDR:
                    read_data = O_OUTPUT_DELAY_SEL;
                `FAULT_FLAGS_ADDR:
                    read_data = {4'h0, O_FAULT_FLAGS};
                default:
                    read_data = 8'h00;
            endcase
        end
        case (O_BLOCK_PROTECT)
            `PROTECT_QUARTER: array_locked = (word_addr >= `ARRAY_UPPER_QUARTER_BASE);
            `PROTECT_HALF:    array_locked = word_addr[7];
            `PROTECT_ALL:     array_locked = 1'b1;
            default:          array_locked = 1'b0;
        endcase
        hw_locked = O_HW_PROTECT_ENABLE && wp_pin;
    end

    // serial engine, register file and nonvolatile cycle timer
    always @(posedge I_CORE_CLK or posedge I_RST) begin
        if (I_RST) begin
            scl_q               <= 1'b1;
            sda_q               <= 1'b1;
            state               <= ST_IDLE;
            bitcnt              <= 4'h0;
            shreg               <= 8'h00;
            txbyte              <= 8'h00;
            word_addr           <= 8'h00;
            pend_data           <= 8'h00;
            have_data           <= 1'b0;
            sector_regs         <= 1'b0;
            read_op             <= 1'b0;
            pgm_fault           <= 1'b0;
            nv_cnt              <= 20'h00000;
            O_SDA_OUT           <= 1'b0;
            O_SDA_OE            <= 1'b0;
            O_WRITE_ENABLE      <= `WRITE_ENABLE_LATCH_RESET;
            O_HW_PROTECT_ENABLE <= `HW_PROTECT_ENABLE_RESET;
            O_BLOCK_PROTECT     <= `BLOCK_PROTECT_RESET;
            O_RESET_DELAY_SEL   <= `RESET_DELAY_SEL_RESET;
            O_OUTPUT_DELAY_SEL  <= `OUTPUT_DELAY_SEL_RESET;
            O_FAULT_FLAGS       <= `FAULT_FLAGS_RESET;
            O_NV_BUSY           <= 1'b0;
            O_STANDBY           <= 1'b1;
        end else begin
            scl_q <= scl_new;
            sda_q <= sda_new;

            // nonvolatile cycle: programming voltage must hold throughout
            if (O_NV_BUSY) begin
                if (!pgm_ok) begin
                    pgm_fault <= 1'b1;
                end
                if (nv_cnt == NV_WRITE_CYCLES - 20'h00001) begin
                    O_NV_BUSY <= 1'b0;
                    nv_cnt    <= 20'h00000;
                end else begin
                    nv_cnt <= nv_cnt + 20'h00001;
                end
            end

            if (start_seen) begin
                // a start always resynchronises the engine; line released
                state     <= ST_ADDR;
                bitcnt    <= 4'h0;
                have_data <= 1'b0;
                O_SDA_OE  <= 1'b0;
                O_STANDBY <= 1'b0;
            end else if (stop_seen) begin
                state    <= ST_IDLE;
                O_SDA_OE <= 1'b0;
                O_STANDBY <= 1'b1;
                // commit only after a whole data byte and its ack; the stop's own clock
                // rise has already been counted as the first bit of a next byte
                if (state == ST_DATA && have_data && bitcnt == 4'h1) begin
                    if (sector_regs) begin
                        case (word_addr)
                            `WRITE_LATCH_CONTROL_ADDR: begin
                                // latch write is volatile, no programming cycle
                                O_WRITE_ENABLE <= pend_data[`WRITE_ENABLE_LATCH_BIT];
                            end
                            `FAULT_FLAGS_ADDR: begin
                                O_FAULT_FLAGS <= pend_data[`FAULT_FLAG_HI_BIT:0];
                            end
                            `EEPROM_PROTECT_CONTROL_ADDR: begin
                                if (O_WRITE_ENABLE && !hw_locked) begin
                                    O_HW_PROTECT_ENABLE <= pend_data[`HW_PROTECT_ENABLE_BIT];
                                    O_BLOCK_PROTECT     <= pend_data[`BLOCK_PROTECT_HI_BIT:
                                                                     `BLOCK_PROTECT_LO_BIT];
                                    O_NV_BUSY           <= 1'b1;
                                end
                            end
                            `RESET_DELAY_CONTROL_ADDR: begin
                                if (O_WRITE_ENABLE && !hw_locked) begin
                                    O_RESET_DELAY_SEL <= pend_data[`RESET_DELAY_SEL_HI_BIT:
                                                                   `RESET_DELAY_SEL_LO_BIT];
                                    O_NV_BUSY         <= 1'b1;
                                end
                            end
                            `OUTPUT_DELAY_CONTROL_ADDR: begin
                                if (O_WRITE_ENABLE && !hw_locked) begin
                                    O_OUTPUT_DELAY_SEL <= pend_data;
                                    O_NV_BUSY          <= 1'b1;
                                end
                            end
                            default: ;  // unmapped register addresses store nothing
                        endcase
                    end else if (O_WRITE_ENABLE && !array_locked) begin
                        O_NV_BUSY <= 1'b1;  // array cell itself sits outside
                    end
                end
            end else if (state != ST_IDLE && scl_rise) begin
                // sample on rising clock
                if (bitcnt < 4'h8) begin
                    shreg  <= {shreg[6:0], sda_new};
                    bitcnt <= bitcnt + 4'h1;
                end else if (bitcnt == 4'h9 && state == ST_READ && sda_new) begin
                    state <= ST_IDLE;
                end
            end else if (state != ST_IDLE && scl_fall) begin
                // the line is pulled only on the falling clock; start and stop also release it
                if (bitcnt == 4'h8) begin
                    bitcnt <= 4'h9;
                    case (state)
                        ST_ADDR: begin
                            sector_regs <= shreg[1];
                            read_op     <= shreg[0];
                            if (addr_match && !O_NV_BUSY && !pgm_fault) begin
                                O_SDA_OE <= 1'b1;
                            end else begin
                                state <= ST_IDLE;
                            end
                        end
                        ST_WORD: begin
                            word_addr <= shreg;
                            O_SDA_OE  <= 1'b1;
                        end
                        ST_DATA: begin
                            if (!have_data) begin
                                pend_data <= shreg;
                            end
                            // a protected array byte gets no ack
                            if (sector_regs || !array_locked) begin
                                O_SDA_OE  <= 1'b1;
                                have_data <= 1'b1;
                            end else begin
                                state <= ST_IDLE;
                            end
                        end
                        ST_READ: O_SDA_OE <= 1'b0;
                        default: state <= ST_IDLE;
                    endcase
                end else if (bitcnt == 4'h9) begin
                    bitcnt   <= 4'h0;
                    O_SDA_OE <= 1'b0;
                    case (state)
                        ST_ADDR: begin
                            if (read_op) begin
                                // read starts at the current pointer
                                state    <= ST_READ;
                                txbyte   <= read_data;
                                O_SDA_OE <= !read_data[7];
                            end else begin
                                state <= ST_WORD;
                            end
                        end
                        ST_WORD: state <= ST_DATA;
                        ST_READ: begin
                            // master acked: next byte, pointer advances
                            word_addr <= word_addr + 8'h01;
                            txbyte    <= read_data;
                            O_SDA_OE  <= !read_data[7];
                            if (sector_regs) begin
                                // register sector reads one byte per transfer
                                state    <= ST_IDLE;
                                O_SDA_OE <= 1'b0;
                            end
                        end
                        default: ;  // data state keeps collecting bytes
                    endcase
                end else if (state == ST_READ && bitcnt != 4'h0) begin
                    O_SDA_OE <= !txbyte[3'h7 - bitcnt[2:0]];
                end
            end

            // a supply-good assertion clears its flag, winning over a write
            if (|good) begin
                O_FAULT_FLAGS <= O_FAULT_FLAGS & ~good;
            end
        end
    end
endmodule

`default_nettype wire

// ==== supervisor_smbus_slave_regs_props.sv ====
// concurrent checks on the ports of the supervisor serial slave port
`default_nettype none
module supervisor_smbus_slave_regs_props #(
    parameter [19:0] NV_WRITE_CYCLES = 20'h7a120  // nonvolatile cycle length
) (
    input wire logic       I_CORE_CLK,
    input wire logic       I_RST,
    input wire logic       I_WRITE_PROTECT,
    input wire logic [3:0] I_SUPPLY_GOOD,
    input wire logic       O_SDA_OUT,
    input wire logic       O_SDA_OE,
    input wire logic       O_WRITE_ENABLE,
    input wire logic       O_HW_PROTECT_ENABLE,
    input wire logic [1:0] O_BLOCK_PROTECT,
    input wire logic [1:0] O_RESET_DELAY_SEL,
    input wire logic [7:0] O_OUTPUT_DELAY_SEL,
    input wire logic [3:0] O_FAULT_FLAGS,
    input wire logic       O_NV_BUSY,
    input wire logic       O_STANDBY
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [19:0] busy_len;  // cycles the current nonvolatile cycle has run
    default clocking cb @(posedge I_CORE_CLK); endclocking
    default disable iff (I_RST);
    // length counter; a full count proves the cycle was neither cut nor stretched
    always_ff @(posedge I_CORE_CLK or posedge I_RST) begin
        if (I_RST) busy_len <= 20'h0;
        else if (O_NV_BUSY) busy_len <= busy_len + 20'h1;
        else busy_len <= 20'h0;
    end
    sequence s_pull_start; $rose(O_SDA_OE); endsequence
    sequence s_pull_stand; O_SDA_OE [*8]; endsequence
    property p_open_drain; O_SDA_OE |-> !O_SDA_OUT; endproperty
    a_open_drain: assert property (p_open_drain) else $error("data driven high");
    property p_pull_stand; s_pull_start |=> s_pull_stand; endproperty
    a_pull_stand: assert property (p_pull_stand) else $error("pull too short");
    property p_frame_only; O_SDA_OE |-> !O_STANDBY; endproperty
    a_frame_only: assert property (p_frame_only) else $error("pull outside frame");
    property p_busy_deaf; s_pull_start |-> !O_NV_BUSY; endproperty
    a_busy_deaf: assert property (p_busy_deaf) else $error("answer while busy");
    property p_busy_len; $fell(O_NV_BUSY) |-> busy_len == NV_WRITE_CYCLES; endproperty
    a_busy_len: assert property (p_busy_len) else $error("busy length wrong");
    property p_nv_gate;
        $changed({O_HW_PROTECT_ENABLE, O_BLOCK_PROTECT, O_RESET_DELAY_SEL, O_OUTPUT_DELAY_SEL})
        |-> $past(O_WRITE_ENABLE) && !($past(O_HW_PROTECT_ENABLE) && $past(I_WRITE_PROTECT));
    endproperty
    a_nv_gate: assert property (p_nv_gate) else $error("guarded write taken");
    property p_commit_busy; $changed({O_RESET_DELAY_SEL, O_OUTPUT_DELAY_SEL}) |-> ##[0:2] O_NV_BUSY;
    endproperty
    a_commit_busy: assert property (p_commit_busy) else $error("no busy on commit");
    property p_flag_clear;
        (I_SUPPLY_GOOD & $past(I_SUPPLY_GOOD, 6) & O_FAULT_FLAGS) == 4'h0;
    endproperty
    a_flag_clear: assert property (p_flag_clear) else $error("flag not cleared");
endmodule
bind supervisor_smbus_slave_regs supervisor_smbus_slave_regs_props #(
    .NV_WRITE_CYCLES(NV_WRITE_CYCLES)) u_props (.I_CORE_CLK(I_CORE_CLK), .I_RST(I_RST),
    .I_WRITE_PROTECT(I_WRITE_PROTECT), .I_SUPPLY_GOOD(I_SUPPLY_GOOD), .O_SDA_OUT(O_SDA_OUT),
    .O_SDA_OE(O_SDA_OE), .O_WRITE_ENABLE(O_WRITE_ENABLE), .O_STANDBY(O_STANDBY),
    .O_HW_PROTECT_ENABLE(O_HW_PROTECT_ENABLE), .O_BLOCK_PROTECT(O_BLOCK_PROTECT),
    .O_RESET_DELAY_SEL(O_RESET_DELAY_SEL), .O_OUTPUT_DELAY_SEL(O_OUTPUT_DELAY_SEL),
    .O_FAULT_FLAGS(O_FAULT_FLAGS), .O_NV_BUSY(O_NV_BUSY));
`default_nettype wire

// ==== smbus_master_model.sv ====
// behavioural serial bus master that clocks the slave port
`default_nettype none
module smbus_master_model (
    output var logic o_scl,       // serial clock, stands high between frames
    output var logic o_sda_pull,  // high while the master pulls data low
    input  wire logic i_sda       // resolved data line level
);
    timeunit 1ns;
    timeprecision 100ps;
    localparam real QTR = 31.25;  // quarter of the 125 ns clock period
    // idle bus: clock high, data released
    initial begin
        o_scl = 1'b1;
        o_sda_pull = 1'b0;
    end
    // one low pulse on the clock before any start, with data high
    task automatic wake();
        #(4 * QTR) o_scl = 1'b0;
        #(4 * QTR) o_scl = 1'b1;
    endtask
    // data set mid-low, sampled mid-high, so it never moves with the clock high
    task automatic bit_cycle(input logic d, output logic s);
        #QTR o_sda_pull = ~d;
        #QTR o_scl = 1'b1;
        #QTR s = i_sda;
        #QTR o_scl = 1'b0;
    endtask
    // start, also used as repeated start from a low clock
    task automatic start();
        #QTR o_sda_pull = 1'b0;
        #QTR o_scl = 1'b1;
        #QTR o_sda_pull = 1'b1;
        #QTR o_scl = 1'b0;
    endtask
    // stop, then a clock fall and return to idle high
    task automatic stop();
        #QTR o_sda_pull = 1'b1;
        #QTR o_scl = 1'b1;
        #QTR o_sda_pull = 1'b0;
        #QTR o_scl = 1'b0;
        #QTR o_scl = 1'b1;
    endtask
    // eight bits out, then release and sample the answer
    task automatic wbyte(input logic [7:0] b, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) bit_cycle(b[i], s);
        bit_cycle(1'b1, s);
        ack = ~s;
    endtask
    // eight bits in; a high ninth bit tells the device to stop sending
    task automatic rbyte(input logic ack, output logic [7:0] b);
        logic s;
        for (int i = 7; i >= 0; i--) bit_cycle(1'b1, b[i]);
        bit_cycle(~ack, s);
    endtask
endmodule
`default_nettype wire

// ==== supervisor_smbus_slave_regs_bench.sv ====
// self-checking bench for the supervisor serial slave port
`default_nettype none
module supervisor_smbus_slave_regs_bench;
    timeunit 1ns;
    timeprecision 100ps;
    localparam int LIMIT = 80000;  // core cycles allowed for the whole run
    logic       clk, rst, wp, pv_ok, sda_oe, sda_out, m_scl, m_pull;  // pins and lines
    logic       we, hwp, busy, stby;  // device status outputs
    logic [1:0] bp, rds;              // protect and reset delay codes
    logic [7:0] ods, d;               // output delay codes, read data
    logic [3:0] sg, ff;               // supply-good inputs, fault flags
    logic [2:0] k;                    // acknowledges of one transfer
    int         n_fail, num_checks, cyc;
    wire        sda = ~((sda_oe & ~sda_out) | m_pull);  // pulled-up open-drain line
    supervisor_smbus_slave_regs #(.NV_WRITE_CYCLES(20'h190)) dut (.I_CORE_CLK(clk),
        .I_RST(rst), .I_SCL(m_scl), .I_SDA(sda), .O_SDA_OUT(sda_out), .O_SDA_OE(sda_oe),
        .I_A1(1'b1), .I_A0(1'b0), .I_WRITE_PROTECT(wp), .I_PROGRAM_VOLTAGE_OK(pv_ok),
        .I_SUPPLY_GOOD(sg), .O_WRITE_ENABLE(we), .O_HW_PROTECT_ENABLE(hwp),
        .O_BLOCK_PROTECT(bp), .O_RESET_DELAY_SEL(rds), .O_OUTPUT_DELAY_SEL(ods),
        .O_FAULT_FLAGS(ff), .O_NV_BUSY(busy), .O_STANDBY(stby));
    smbus_master_model mst (.o_scl(m_scl), .o_sda_pull(m_pull), .i_sda(sda));
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // hang guard
    always @(posedge clk) begin
        cyc++;
        if (cyc == LIMIT) begin
            n_fail++;
            $display("CHECK FAILED t=%0t run too long", $time);
            give_verdict();
        end
    end
    task automatic give_verdict();
        $display("checks %0d failures %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string m);
        num_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("CHECK FAILED t=%0t %s got %h exp %h", $time, m, got, exp);
        end
    endtask
    task automatic pins(input logic w, input logic p, input logic [3:0] s);
        @(posedge clk) #1 wp = w;
        pv_ok = p;
        sg = s;
    endtask
    task automatic do_reset();
        @(posedge clk) #1 rst = 1'b1;
        repeat (4) @(posedge clk);
        #1 rst = 1'b0;
        repeat (6) @(posedge clk);
    endtask
    // bounded wait for the end of a nonvolatile cycle
    task automatic wait_idle();
        repeat (4) @(posedge clk);
        for (int i = 0; i < 600 && busy !== 1'b0; i++) @(posedge clk);
        chk({7'h0, busy}, 8'h00, "busy stuck");
    endtask
    // address, word address, data, stop; acknowledges compared
    task automatic wr(input logic [7:0] sa, a, v, input logic [2:0] exp);
        mst.start();
        mst.wbyte(sa, k[2]);
        mst.wbyte(a, k[1]);
        mst.wbyte(v, k[0]);
        mst.stop();
        chk({5'h0, k}, {5'h0, exp}, "acks");
    endtask
    task automatic reg_set(input logic [7:0] a, v);
        wr(8'haa, a, v, 3'h7);
        wait_idle();
    endtask
    // dummy write, repeated start, one byte ended by no acknowledge
    task automatic rd(input logic [7:0] a, exp);
        mst.start();
        mst.wbyte(8'haa, k[2]);
        mst.wbyte(a, k[1]);
        mst.start();
        mst.wbyte(8'hab, k[0]);
        mst.rbyte(1'b0, d);
        mst.stop();
        chk({5'h0, k}, 8'h07, "read acks");
        chk(d, exp, "read data");
    endtask
    task automatic nack_probe(input logic [7:0] sa, input string m);
        mst.start();
        mst.wbyte(sa, k[0]);
        mst.stop();
        chk({7'h0, k[0]}, 8'h00, m);
    endtask
    task automatic t_reset();
        chk({2'h0, we, hwp, bp, rds}, 8'h00, "ctrl reset");
        chk(ods, 8'h00, "delay reset");
        chk({sda_out, ff, busy, stby, sda_oe}, 8'h02, "status reset");
        rd(8'h01, 8'h00);
    endtask
    task automatic t_addr();
        nack_probe(8'h5a, "type nack");
        nack_probe(8'ha2, "select nack");
        wr(8'haa, 8'h01, 8'h98, 3'h7);
        wait_idle();
        chk({5'h0, hwp, bp}, 8'h00, "latch clear write");
        reg_set(8'h00, 8'h80);
        chk({7'h0, we}, 8'h01, "latch set");
    endtask
    task automatic t_codes();
        for (int c = 0; c < 4; c++) begin
            reg_set(8'h01, 8'(c << 3));
            chk({6'h0, bp}, 8'(c), "protect code");
            reg_set(8'h02, 8'(c << 2));
            chk({6'h0, rds}, 8'(c), "reset delay code");
        end
        wr(8'ha8, 8'h10, 8'h55, 3'h6);
        wait_idle();
        reg_set(8'h01, 8'h08);
        wr(8'ha8, 8'hc0, 8'h55, 3'h6);
        wait_idle();
        wr(8'ha8, 8'hbf, 8'h55, 3'h7);
        wait_idle();
    endtask
    task automatic t_delay();
        reg_set(8'h03, 8'he4);
        chk(ods, 8'he4, "output delays");
        rd(8'h03, 8'he4);
        wr(8'haa, 8'h03, 8'h1b, 3'h7);
        nack_probe(8'haa, "busy nack");
        wait_idle();
        chk(ods, 8'h1b, "output delays");
    endtask
    task automatic t_hwprot();
        reg_set(8'h01, 8'h80);
        chk({7'h0, hwp}, 8'h01, "protect bit");
        pins(1'b1, 1'b1, 4'h0);
        reg_set(8'h02, 8'h08);
        chk({6'h0, rds}, 8'h03, "protected write");
        pins(1'b0, 1'b1, 4'h0);
        reg_set(8'h02, 8'h08);
        chk({6'h0, rds}, 8'h02, "unprotected write");
    endtask
    task automatic t_flags();
        reg_set(8'h00, 8'h00);
        reg_set(8'hff, 8'h0f);
        chk({we, 3'h0, ff}, 8'h0f, "flag preset");
        pins(1'b0, 1'b1, 4'h2);
        repeat (10) @(posedge clk);
        chk({4'h0, ff}, 8'h0d, "flag cleared");
        rd(8'hff, 8'h0d);
        pins(1'b0, 1'b1, 4'h0);
    endtask
    task automatic t_array();
        mst.start();
        mst.wbyte(8'ha8, k[0]);
        mst.wbyte(8'h00, k[0]);
        mst.start();
        mst.wbyte(8'ha9, k[0]);
        chk({7'h0, stby}, 8'h00, "active in frame");
        mst.rbyte(1'b1, d);
        chk(d, 8'hff, "array byte 1");
        mst.rbyte(1'b0, d);
        chk(d, 8'hff, "array byte 2");
        mst.stop();
        repeat (4) @(posedge clk);
        chk({7'h0, stby}, 8'h01, "standby after read");
    endtask
    task automatic t_pgm();
        reg_set(8'h00, 8'h80);
        wr(8'haa, 8'h03, 8'h55, 3'h7);
        pins(1'b0, 1'b0, 4'h0);
        repeat (20) @(posedge clk);
        pins(1'b0, 1'b1, 4'h0);
        wait_idle();
        nack_probe(8'haa, "no ack after drop");
        do_reset();
        chk(ods, 8'h00, "delay after reset");
        wr(8'haa, 8'h00, 8'h80, 3'h7);
        wait_idle();
    endtask
    initial begin
        rst = 1'b1;
        wp = 1'b0;
        pv_ok = 1'b1;
        sg = 4'h0;
        do_reset();
        mst.wake();
        t_reset();
        t_addr();
        t_codes();
        t_delay();
        t_hwprot();
        t_flags();
        t_array();
        t_pgm();
        give_verdict();
    end
endmodule
`default_nettype wire
